// *** uart_c2_pkg.sv ***
package uart_c2_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFF_CTRL2  = 4'h0;
    localparam logic [3:0] OFF_CONFIG = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;

    // Control register two field positions
    localparam int C2_TX_EMPTY_IE = 7;
    localparam int C2_DONE_IE     = 6;
    localparam int C2_RCV_IE      = 5;
    localparam int C2_IDLE_IE     = 4;
    localparam int C2_XMIT_ON     = 3;
    localparam int C2_RX_ON       = 2;
    localparam int C2_RCV_SLEEP   = 1;
    localparam int C2_BREAK_QUEUE = 0;

    // Configuration register field positions
    localparam int CFG_LOOPBACK   = 0;
    localparam int CFG_RCV_SOURCE = 1;
    localparam int CFG_WIRE_DIR   = 2;
    localparam int CFG_LONG_BREAK = 3;
    localparam int CFG_WAKE_SEL   = 4;
    localparam int CFG_NINE_BIT   = 5;
    localparam int CFG_PARITY     = 6;

    // Status register field positions
    localparam int ST_TX_EMPTY  = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_RCV_FULL  = 2;
    localparam int ST_QUIET     = 3;
    localparam int ST_TX_OWN    = 4;
    localparam int ST_RX_OWN    = 5;
    localparam int ST_GEN_BUSY  = 6;
    localparam int ST_IRQ       = 7;

    // Reset values
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;

    // Special character lengths in bit times
    localparam logic [3:0] CHAR_BITS_BASE = 4'ha;
    localparam logic [3:0] BREAK_BITS_LONG = 4'hd;
    localparam logic [3:0] BITS_ONE        = 4'h1;

    // Special character generator states, Gray along rest, break, idle
    typedef enum logic [1:0] {
        GEN_REST  = 2'b00,
        GEN_BREAK = 2'b01,
        GEN_IDLE  = 2'b11
    } gen_e;
endpackage

// *** pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
    parameter int         W   = 2,
    parameter logic [1:0] RST = 2'h3
) (
    input  wire logic         sys_clk,   // Module clock
    input  wire logic         resetn,    // Synchronous reset, active low
    input  wire logic         clk_en,    // Freezes state while low
    input  wire logic [W-1:0] pin_in,    // Asynchronous pin levels
    output logic      [W-1:0] pin_out    // Filtered levels, registered
);
    // Three stages and the accepted level
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s        s_q;    // Present state
    sync_s        s_d;    // Next state
    logic [W-1:0] agree;  // Stages two and three equal, per bit

    // Shift chain, accept a level once stages two and three agree
    always_comb begin
        s_d     = s_q;
        s_d.s1  = pin_in;
        s_d.s2  = s_q.s1;
        s_d.s3  = s_q.s2;
        // Hold the old level while the stages still disagree
        s_d.lvl = (agree & s_q.s3) | (~agree & s_q.lvl);
    end

    // Per bit agreement of stages two and three
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agree[i] = (s_q.s2[i] == s_q.s3[i]);
    end

    // State register, every stage resets to the idle level
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_q <= {4{RST[W-1:0]}};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.lvl;
endmodule

// *** uart_c2_ctrl.sv ***
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
// Overview of operation
// - Transmit empty enable gates empty flag interrupt
// - Done enable gates send done interrupt
// - Receive enable gates buffer full interrupt
// - Idle enable gates quiet line interrupt
// - Transmitter runs and drives pin when on
// - Single wire mode: direction bit steers pin
// - Off then on while busy queues idle
// - Pin held until pending characters finish
// - Receiver active only while receive enabled
// - Loopback releases receive pin always
// - Writing sleep puts receiver in standby
// - Wake by idle line or address mark
// - Hardware clears sleep on wake condition while receive enabled
// - Writing one then zero queues break
// - Breaks repeat while queue bit held and transmitter on
// - A second break may be queued
// - Control register accessible at any time
// - Loopback feeds receiver from transmit path
// - Address mark bit eight or nine
module uart_c2_ctrl (
    input  wire logic        sys_clk,          // Module clock, 100 MHz
    input  wire logic        resetn,           // Synchronous reset, active low
    input  wire logic        clk_en,           // Freezes all state while low
    input  wire logic [3:0]  avs_address,      // Byte address
    input  wire logic        avs_read,         // Read request
    input  wire logic        avs_write,        // Write request
    input  wire logic [31:0] avs_writedata,    // Write data
    output logic      [31:0] avs_readdata,     // Read data
    output logic             avs_waitrequest,  // Stall the master
    input  wire logic        tx_buf_empty,     // Transmit buffer empty flag
    input  wire logic        send_done_flag,   // Transmission complete flag
    input  wire logic        rcv_buf_full,     // Receive buffer full flag
    input  wire logic        line_quiet_flag,  // Idle line flag
    input  wire logic        bit_tick,         // One pulse per bit time
    input  wire logic        data_busy,        // Data shifter sending
    input  wire logic        data_bit,         // Data shifter output bit
    input  wire logic        rx_char_done,     // Received character pulse
    input  wire logic        rx_msb8,          // Eighth data bit of it
    input  wire logic        rx_msb9,          // Ninth data bit of it
    input  wire logic        rx_idle_seen,     // Idle line detected pulse
    input  wire logic        tx_pin_i,         // Transmit pin level in
    output logic             tx_pin_o,         // Transmit pin level out
    output logic             tx_pin_oe_n,      // Pin drive enable, low drives
    output logic             tx_pin_owned,     // Pin held by transmitter
    input  wire logic        rx_pin_i,         // Receive pin level in
    output logic             rx_pin_owned,     // Pin held by receiver
    output logic             rx_line,          // Serial input to receiver
    output logic             xmit_run,         // Shifter may start data
    output logic             rcv_run,          // Receiver active
    output logic             rcv_asleep,       // Receiver in standby
    output logic             irq               // Interrupt request
);
    // All state of the block
    typedef struct packed {
        logic [7:0]           ctrl2;      // Control register two
        logic [7:0]           cfg;        // Configuration register
        uart_c2_pkg::gen_e    gen;        // Special character state
        logic [3:0]           bits_left;  // Bit times left in character
        logic                 brk_pend;   // One break owed
        logic                 idle_pend;  // One idle character owed
        logic                 wait_q;     // Waitrequest
        logic [7:0]           rdata;      // Read data
        logic                 tx_o;       // Pin level
        logic                 tx_oe_n;    // Pin drive enable
        logic                 tx_own;     // Transmitter holds pin
        logic                 rx_own;     // Receiver holds pin
        logic                 rx_line;    // Receiver input
        logic                 irq;        // Interrupt
    } state_s;

    state_s s_q;  // Present state
    state_s s_d;  // Next state

    logic [1:0] pins_sync;  // Filtered pin levels, tx then rx
    logic       irq_cond;   // Any enabled flag raised
    logic       busy;       // Any transmit traffic
    logic       wr_c2;      // Accepted write to control two
    logic       wake;       // Wake condition seen
    logic       single;     // Single wire mode
    logic [3:0] char_len;   // Idle or break length
    logic [7:0] wdat;       // Low write byte

    // Pin synchronisers
    pin_sync #(
        .W   (2),
        .RST (2'h3)
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pin_in  ({tx_pin_i, rx_pin_i}),
        .pin_out (pins_sync)
    );

    assign wdat   = avs_writedata[7:0];
    assign wr_c2  = avs_write && !s_q.wait_q && (avs_address == uart_c2_pkg::OFF_CTRL2);
    assign single = s_q.cfg[uart_c2_pkg::CFG_LOOPBACK] && s_q.cfg[uart_c2_pkg::CFG_RCV_SOURCE];
    assign busy   = data_busy || (s_q.gen != uart_c2_pkg::GEN_REST)
                    || s_q.brk_pend || s_q.idle_pend;

    assign irq_cond = (s_q.ctrl2[uart_c2_pkg::C2_TX_EMPTY_IE] && tx_buf_empty)
                    || (s_q.ctrl2[uart_c2_pkg::C2_DONE_IE] && send_done_flag)
                    || (s_q.ctrl2[uart_c2_pkg::C2_RCV_IE] && rcv_buf_full)
                    || (s_q.ctrl2[uart_c2_pkg::C2_IDLE_IE] && line_quiet_flag);

    always_comb begin
        if (s_q.cfg[uart_c2_pkg::CFG_WAKE_SEL]) begin
            // Address mark
            wake = rx_char_done
                   && (s_q.cfg[uart_c2_pkg::CFG_NINE_BIT] ? rx_msb9 : rx_msb8);
        end else begin
            // Idle line
            wake = rx_idle_seen;
        end
    end

    // break and idle length by frame size
    always_comb begin
        char_len = s_q.cfg[uart_c2_pkg::CFG_LONG_BREAK] && (s_q.gen != uart_c2_pkg::GEN_IDLE)
                   ? uart_c2_pkg::BREAK_BITS_LONG : uart_c2_pkg::CHAR_BITS_BASE;
        char_len = char_len + {3'h0, s_q.cfg[uart_c2_pkg::CFG_NINE_BIT]}
                   + {3'h0, s_q.cfg[uart_c2_pkg::CFG_PARITY]};
    end

    // Next state
    always_comb begin
        s_d = s_q;
        // Bus answer one cycle after request
        s_d.wait_q = !((avs_read || avs_write) && s_q.wait_q);
        if (avs_read && s_q.wait_q) begin
            case (avs_address)
                uart_c2_pkg::OFF_CTRL2: begin
                    s_d.rdata = s_q.ctrl2;
                end
                uart_c2_pkg::OFF_CONFIG: begin
                    s_d.rdata = s_q.cfg;
                end
                uart_c2_pkg::OFF_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[uart_c2_pkg::ST_TX_EMPTY] = tx_buf_empty;
                    s_d.rdata[uart_c2_pkg::ST_DONE]     = send_done_flag;
                    s_d.rdata[uart_c2_pkg::ST_RCV_FULL] = rcv_buf_full;
                    s_d.rdata[uart_c2_pkg::ST_QUIET]    = line_quiet_flag;
                    s_d.rdata[uart_c2_pkg::ST_TX_OWN]   = s_q.tx_own;
                    s_d.rdata[uart_c2_pkg::ST_RX_OWN]   = s_q.rx_own;
                    s_d.rdata[uart_c2_pkg::ST_GEN_BUSY] = (s_q.gen != uart_c2_pkg::GEN_REST);
                    s_d.rdata[uart_c2_pkg::ST_IRQ]      = s_q.irq;
                end
                // Unmapped reads as zero
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        if (wake && s_q.ctrl2[uart_c2_pkg::C2_RX_ON]) begin
            s_d.ctrl2[uart_c2_pkg::C2_RCV_SLEEP] = 1'b0;
        end

        // Special character generator
        case (s_q.gen)
            uart_c2_pkg::GEN_REST: begin
                if (!data_busy) begin
                    if (s_q.brk_pend
                        || (s_q.ctrl2[uart_c2_pkg::C2_BREAK_QUEUE]
                            && s_q.ctrl2[uart_c2_pkg::C2_XMIT_ON])) begin
                        s_d.gen       = uart_c2_pkg::GEN_BREAK;
                        s_d.brk_pend  = 1'b0;
                        s_d.bits_left = '0;
                    end else if (s_q.idle_pend) begin
                        s_d.gen       = uart_c2_pkg::GEN_IDLE;
                        s_d.idle_pend = 1'b0;
                        s_d.bits_left = '0;
                    end
                end
            end
            uart_c2_pkg::GEN_BREAK, uart_c2_pkg::GEN_IDLE: begin
                // Count bit times, load length on first tick
                if (bit_tick) begin
                    if (s_q.bits_left == '0) begin
                        s_d.bits_left = char_len - uart_c2_pkg::BITS_ONE;
                    end else if (s_q.bits_left == uart_c2_pkg::BITS_ONE) begin
                        s_d.gen       = uart_c2_pkg::GEN_REST;
                        s_d.bits_left = '0;
                    end else begin
                        s_d.bits_left = s_q.bits_left - uart_c2_pkg::BITS_ONE;
                    end
                end
            end
            default: begin
                s_d.gen = uart_c2_pkg::GEN_REST;
            end
        endcase

        // Register writes, set wins over hardware clears
        if (avs_write && !s_q.wait_q) begin
            case (avs_address)
                uart_c2_pkg::OFF_CTRL2: begin
                    s_d.ctrl2 = wdat;
                    if (wdat[uart_c2_pkg::C2_XMIT_ON]
                        && !s_q.ctrl2[uart_c2_pkg::C2_XMIT_ON] && busy) begin
                        s_d.idle_pend = 1'b1;
                    end
                    // rising queue bit owes one break
                    // it may add to a held repeat
                    if (wdat[uart_c2_pkg::C2_BREAK_QUEUE]
                        && !s_q.ctrl2[uart_c2_pkg::C2_BREAK_QUEUE]) begin
                        s_d.brk_pend = 1'b1;
                    end
                end
                uart_c2_pkg::OFF_CONFIG: begin
                    s_d.cfg = wdat;
                end
                // Status and unmapped ignore writes
                default: begin
                    s_d.cfg = s_q.cfg;
                end
            endcase
        end

        s_d.tx_own = s_q.ctrl2[uart_c2_pkg::C2_XMIT_ON] || busy;
        s_d.tx_oe_n = !(s_q.tx_own && (!single || s_q.cfg[uart_c2_pkg::CFG_WIRE_DIR]));
        // Pin level: data, break low, else mark
        if (data_busy) begin
            s_d.tx_o = data_bit;
        end else begin
            s_d.tx_o = (s_q.gen != uart_c2_pkg::GEN_BREAK);
        end
        // receiver holds pin only when on
        s_d.rx_own = s_q.ctrl2[uart_c2_pkg::C2_RX_ON] && !s_q.cfg[uart_c2_pkg::CFG_LOOPBACK];
        // loopback sources receiver from transmit side
        if (s_q.cfg[uart_c2_pkg::CFG_LOOPBACK]) begin
            s_d.rx_line = s_q.cfg[uart_c2_pkg::CFG_RCV_SOURCE] ? pins_sync[1] : s_q.tx_o;
        end else begin
            s_d.rx_line = pins_sync[0];
        end
        s_d.irq = irq_cond;
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.ctrl2   <= uart_c2_pkg::CTRL2_RST;
            s_q.cfg     <= uart_c2_pkg::CONFIG_RST;
            s_q.wait_q  <= 1'b1;
            s_q.tx_o    <= 1'b1;
            s_q.tx_oe_n <= 1'b1;
            s_q.rx_line <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign avs_readdata    = {24'h00_0000, s_q.rdata};
    assign avs_waitrequest = s_q.wait_q;
    assign tx_pin_o        = s_q.tx_o;
    assign tx_pin_oe_n     = s_q.tx_oe_n;
    assign tx_pin_owned    = s_q.tx_own;
    assign rx_pin_owned    = s_q.rx_own;
    assign rx_line         = s_q.rx_line;
    assign xmit_run        = s_q.ctrl2[uart_c2_pkg::C2_XMIT_ON];
    assign rcv_run         = s_q.ctrl2[uart_c2_pkg::C2_RX_ON];
    assign rcv_asleep      = s_q.ctrl2[uart_c2_pkg::C2_RCV_SLEEP];
    assign irq             = s_q.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Bus answers next cycle and only once
    wait_ack_a: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no bus answer");
    ack_once_a: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    irq_map_a: assert property ($past(clk_en) |-> irq == $past(irq_cond))
        else $error("irq not the OR of enabled flags");
    tx_drive_a: assert property (clk_en && xmit_run |=> tx_pin_owned)
        else $error("pin not held while on");
    drain_hold_a: assert property (clk_en && s_q.gen != uart_c2_pkg::GEN_REST
        |=> tx_pin_owned) else $error("pin released during character");
    wire_dir_a: assert property (clk_en && single
        && !s_q.cfg[uart_c2_pkg::CFG_WIRE_DIR] |=> tx_pin_oe_n)
        else $error("driving against wire direction");
    rx_release_a: assert property ($past(clk_en) |-> rx_pin_owned
        == $past(rcv_run && !s_q.cfg[uart_c2_pkg::CFG_LOOPBACK]))
        else $error("receive pin ownership wrong");
    break_low_a: assert property (clk_en && s_q.gen == uart_c2_pkg::GEN_BREAK
        && !data_busy |=> !tx_pin_o) else $error("break not low");
    break_start_a: assert property (clk_en && s_q.brk_pend
        && s_q.gen == uart_c2_pkg::GEN_REST && !data_busy
        |=> s_q.gen == uart_c2_pkg::GEN_BREAK) else $error("owed break not sent");
    wake_clear_a: assert property (clk_en && wake && rcv_run && !wr_c2
        |=> !rcv_asleep) else $error("sleep not cleared on wake");
    idle_queue_a: assert property (clk_en && wr_c2 && busy
        && avs_writedata[uart_c2_pkg::C2_XMIT_ON] && !xmit_run |=> s_q.idle_pend)
        else $error("idle character not owed");
    loop_src_a: assert property (clk_en && s_q.cfg[uart_c2_pkg::CFG_LOOPBACK]
        && !s_q.cfg[uart_c2_pkg::CFG_RCV_SOURCE] |=> rx_line == $past(tx_pin_o))
        else $error("loopback source wrong");

    break_sent_c: cover property (s_q.gen == uart_c2_pkg::GEN_BREAK
        ##1 s_q.gen == uart_c2_pkg::GEN_REST);
    idle_sent_c: cover property (s_q.gen == uart_c2_pkg::GEN_IDLE);
    woke_c: cover property (rcv_asleep ##1 !rcv_asleep);
endmodule

// *** line_peer.sv ***
`timescale 1ns/1ns
// Remote serial device on the line side of the block
module line_peer (
    input  wire logic tx_pin_o,     // Level the block drives
    input  wire logic tx_pin_oe_n,  // Block drive enable, low drives
    input  wire logic peer_talk,    // Peer drives its lines
    input  wire logic peer_bit,     // Level the peer sends
    output logic      tx_pin_i,     // Resolved shared wire
    output logic      rx_pin_i      // Peer line into receive pin
);
    // Shared wire: block wins, then the peer, else the pull-up
    always_comb begin
        if (!tx_pin_oe_n) begin
            tx_pin_i = tx_pin_o;
        end else if (peer_talk) begin
            tx_pin_i = peer_bit;
        end else begin
            tx_pin_i = 1'b1;
        end
    end
    // Receive line idles high when the peer is silent
    assign rx_pin_i = peer_talk ? peer_bit : 1'b1;
endmodule

// *** uart_control_two_logic_bench.sv ***
`timescale 1ns/1ns
module uart_control_two_logic_bench;
    localparam logic [3:0] A_C2 = uart_c2_pkg::OFF_CTRL2;   // Control two
    localparam logic [3:0] A_CF = uart_c2_pkg::OFF_CONFIG;  // Configuration
    localparam logic [3:0] A_ST = uart_c2_pkg::OFF_STATUS;  // Status
    logic        sys_clk, resetn, clk_en;                    // Clock, reset, enable
    logic [3:0]  avs_address;                                // Bus address
    logic        avs_read, avs_write, avs_waitrequest;       // Bus control
    logic [31:0] avs_writedata, avs_readdata;                // Bus data
    logic [3:0]  flags;                                      // Quiet, full, done, empty
    logic        bit_tick, data_busy, rx_char_done;          // Core strobes
    logic        rx_msb8, rx_msb9, rx_idle_seen;             // Receive events
    logic        tx_pin_i, tx_pin_o, tx_pin_oe_n, tx_pin_owned; // Transmit pin
    logic        rx_pin_i, rx_pin_owned, rx_line;            // Receive pin
    logic        xmit_run, rcv_run, rcv_asleep, irq;         // Status outputs
    logic        peer_talk, peer_bit;                        // Peer controls
    logic [7:0]  exp_q[$], msk_q[$];                         // Expected reads
    logic [31:0] seed, r;                                    // Random state
    logic [3:0]  en, fl;                                     // Enables, flags
    int          n_fail, total_checks, tick_cnt;             // Counters

    uart_c2_ctrl i_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_buf_empty(flags[0]),
        .send_done_flag(flags[1]), .rcv_buf_full(flags[2]), .line_quiet_flag(flags[3]),
        .bit_tick(bit_tick), .data_busy(data_busy), .data_bit(1'b1),
        .rx_char_done(rx_char_done), .rx_msb8(rx_msb8), .rx_msb9(rx_msb9),
        .rx_idle_seen(rx_idle_seen), .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o),
        .tx_pin_oe_n(tx_pin_oe_n), .tx_pin_owned(tx_pin_owned), .rx_pin_i(rx_pin_i),
        .rx_pin_owned(rx_pin_owned), .rx_line(rx_line), .xmit_run(xmit_run),
        .rcv_run(rcv_run), .rcv_asleep(rcv_asleep), .irq(irq));
    line_peer i_peer (.tx_pin_o(tx_pin_o), .tx_pin_oe_n(tx_pin_oe_n), .peer_talk(peer_talk),
        .peer_bit(peer_bit), .tx_pin_i(tx_pin_i), .rx_pin_i(rx_pin_i));

    // Free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // One bit time every four clocks
    always @(posedge sys_clk) begin
        tick_cnt <= (tick_cnt == 3) ? 0 : tick_cnt + 1;
        bit_tick <= (tick_cnt == 3);
    end
    // Read monitor: oldest note against the returned data
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            total_checks++;
            if ((avs_readdata & {24'hff_ffff, msk_q[0]}) !== {24'h00_0000, exp_q[0] & msk_q[0]})
            begin
                n_fail++;
                $display("MISMATCH at %0t: read %h expected %h", $time, avs_readdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // Xorshift generator
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Direct level compare
    task automatic chk(input logic g, input logic e, input string s);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, s);
        end
    endtask
    // One bus access; a read notes its expected byte and mask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] m);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            results();
        end
    endtask
    // Queue one break and measure its low time in bit times
    task automatic brk(input logic [7:0] cfg, input logic [7:0] last, input int len);
        int n, t;
        n = 0;
        t = 0;
        bus(1'b1, A_CF, cfg, 8'h00);
        fork
            begin
                while (tx_pin_o !== 1'b0 && n < 50) begin
                    @(posedge sys_clk);
                    n++;
                end
                while (tx_pin_o === 1'b0 && n < 400) begin
                    chk(tx_pin_owned, 1'b1, "pin released during break");
                    @(posedge sys_clk);
                    n++;
                    t += bit_tick;
                end
            end
            begin
                bus(1'b1, A_C2, 8'h09, 8'h00);
                bus(1'b1, A_C2, last, 8'h00);
            end
        join
        chk(t >= len - 1 && t <= 2 * len, 1'b1, "break length");
        if (t < len - 1 || t > 2 * len) results();
        repeat (3) @(posedge sys_clk);
        bus(1'b0, A_ST, {3'h0, last[3], 4'h0}, 8'h50);
    endtask
    // Sleep, one wake event, then read back control two
    task automatic wake(input logic [7:0] cfg, input logic idle, input logic m8,
                        input logic m9, input logic [7:0] e);
        bus(1'b1, A_CF, cfg, 8'h00);
        bus(1'b1, A_C2, 8'h06, 8'h00);
        rx_idle_seen <= idle;
        rx_char_done <= !idle;
        rx_msb8 <= m8;
        rx_msb9 <= m9;
        @(posedge sys_clk);
        rx_idle_seen <= 1'b0;
        rx_char_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        bus(1'b0, A_C2, e, 8'hff);
        chk(rcv_asleep, e[1], "standby level");
    endtask
    // Verdict and end of run
    task automatic results();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {n_fail, total_checks} = '0;
        seed = 32'h32d3_2edd;
        {resetn, avs_address, avs_read, avs_write, avs_writedata, flags} = '0;
        {data_busy, rx_char_done, rx_msb8, rx_msb9, rx_idle_seen} = '0;
        {clk_en, peer_talk, peer_bit} = 3'b101;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, A_C2, uart_c2_pkg::CTRL2_RST, 8'hff);
        bus(1'b0, A_CF, uart_c2_pkg::CONFIG_RST, 8'hff);
        bus(1'b1, A_ST, 8'hff, 8'h00);
        bus(1'b0, A_ST, 8'h00, 8'hff);
        bus(1'b0, 4'hc, 8'h00, 8'hff);
        // Enable and flag combinations, walking then random
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            en = (k < 8) ? (4'h1 << k[1:0]) : r[3:0];
            fl = (k < 8) ? (k[2] ? (4'h8 >> k[1:0]) : ~(4'h8 >> k[1:0])) : r[7:4];
            bus(1'b1, A_C2, {en, 4'h0}, 8'h00);
            flags <= fl;
            repeat (2) @(posedge sys_clk);
            bus(1'b0, A_C2, {en, 4'h0}, 8'hff);
            bus(1'b0, A_ST, {|(en & {fl[0], fl[1], fl[2], fl[3]}), 3'h0, fl}, 8'h8f);
        end
        flags <= 4'h0;
        peer_talk <= 1'b1;
        peer_bit <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, A_CF, {7'h00, k[1]}, 8'h00);
            bus(1'b1, A_C2, {5'h00, k[0], 2'h0}, 8'h00);
            repeat (6) @(posedge sys_clk);
            bus(1'b0, A_ST, {2'h0, k[0] & !k[1], 5'h00}, 8'h20);
            if (k[0]) chk(rx_line, k[1], "receive source");
            chk(rcv_run, k[0], "receiver run");
        end
        bus(1'b1, A_CF, 8'h07, 8'h00);
        bus(1'b1, A_C2, 8'h0c, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk(tx_pin_oe_n, 1'b0, "single wire drive");
        bus(1'b1, A_CF, 8'h03, 8'h00);
        repeat (7) @(posedge sys_clk);
        chk(tx_pin_oe_n, 1'b1, "single wire input");
        chk(rx_line, 1'b0, "single wire receive");
        peer_talk <= 1'b0;
        wake(8'h00, 1'b1, 1'b0, 1'b0, 8'h04);
        wake(8'h00, 1'b0, 1'b1, 1'b0, 8'h06);
        wake(8'h10, 1'b1, 1'b0, 1'b0, 8'h06);
        wake(8'h10, 1'b0, 1'b0, 1'b0, 8'h06);
        wake(8'h10, 1'b0, 1'b1, 1'b0, 8'h04);
        wake(8'h30, 1'b0, 1'b1, 1'b0, 8'h06);
        wake(8'h30, 1'b0, 1'b0, 1'b1, 8'h04);
        bus(1'b1, A_C2, 8'h08, 8'h00);
        bus(1'b0, A_ST, 8'h10, 8'h50);
        brk(8'h60, 8'h08, 12);
        brk(8'h08, 8'h08, 13);
        brk(8'h00, 8'h00, 10);
        bus(1'b1, A_C2, 8'h09, 8'h00);
        repeat (100) @(posedge sys_clk);
        bus(1'b0, A_ST, 8'h50, 8'h50);
        chk(tx_pin_o, 1'b0, "held break level");
        bus(1'b1, A_C2, 8'h08, 8'h00);
        repeat (120) @(posedge sys_clk);
        bus(1'b0, A_ST, 8'h10, 8'h50);
        data_busy <= 1'b1;
        bus(1'b1, A_C2, 8'h00, 8'h00);
        bus(1'b1, A_C2, 8'h08, 8'h00);
        data_busy <= 1'b0;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, A_ST, 8'h50, 8'h50);
        chk(tx_pin_o, 1'b1, "idle level");
        chk(xmit_run, 1'b1, "transmitter on");
        repeat (60) @(posedge sys_clk);
        bus(1'b1, A_C2, 8'h00, 8'h00);
        repeat (3) @(posedge sys_clk);
        bus(1'b0, A_ST, 8'h00, 8'h50);
        chk(tx_pin_oe_n, 1'b1, "pin returned");
        bus(1'b1, A_C2, 8'h10, 8'h00);
        clk_en <= 1'b0;
        flags <= 4'h8;
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b0, "irq moved while frozen");
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1, "irq pin");
        results();
    end
endmodule
